// ---- hw/sound_pkg.sv ----
`default_nettype none
package sound_pkg;
	// ----------------------------------------------------------------
	// Register map (printed offsets not all multiples of four: index*4)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_TONE0_LOW   = 8'h10;
	localparam logic [7:0] IDX_TONE0_HIGH  = 8'h11;
	localparam logic [7:0] IDX_TONE1_LOW   = 8'h12;
	localparam logic [7:0] IDX_TONE1_HIGH  = 8'h13;
	localparam logic [7:0] IDX_DAC_SAMPLE  = 8'h14;
	localparam logic [7:0] IDX_CONTROL     = 8'h16;
	localparam logic [7:0] IDX_VOLUME      = 8'h17;
	localparam logic [7:0] IDX_STATUS      = 8'h18;
	localparam logic [7:0] RST_BYTE        = 8'h00;
	localparam logic [3:0] RST_NIBBLE      = 4'h0;
	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int CTL_DAC_FUNC = 0;
	localparam int CTL_BIT1     = 1;
	localparam int CTL_BIT2     = 2;
	localparam int CTL_BIT3     = 3;
	localparam int CTL_CLK_LSB  = 4;
	localparam logic [12:0] TONE_BASE  = 13'h1000;
	localparam logic [6:0]  NOISE_BASE = 7'h40;
	localparam logic [6:0]  SEGMENTS   = 7'h7F;
	localparam logic [16:0] LFSR_SEED  = 17'h00001;
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_TWO    = 2'h1;
	localparam logic [1:0] MODE_PUSH   = 2'h3;
	typedef struct packed {
		logic [11:0] chan0_period;
		logic [11:0] chan1_period;
		logic [7:0]  dac_sample;
		logic [7:0]  control;
		logic [7:0]  volume;
	} sound_regs_t;
endpackage : sound_pkg
`default_nettype wire

// ---- hw/sound_generator_pwm_dac.sv ----
// Operation
// - Sound clock from select field: sys/2,/4,/8,/16, sys, or slow crystal.
// - Tone toggles every 1000H minus period sound clocks: square wave.
// - Control bit 0 one selects DAC, zero selects tone/noise.
// - Tone mode: bit 1 enables channel 0 tone.
// - Tone mode: bit 2 enables channel 1, tone or noise.
// - Tone mode: bit 3 picks noise (one) or tone (zero) on channel 1.
// - Three playing types: two tones, tone plus noise, PCM DAC.
// - Noise clock is sound clock over 40H minus channel 1 low six bits.
// - Four-bit volume per channel; zero silent, n gives n/16 duty.
// - With one channel enabled, volume range doubles to 32 levels.
// - Output runs autonomously until settings change.
// - DAC mode: bit 1 inhibits outputs.
// - DAC mode: bits 3:2 pick single, two-ended or push-pull output.
// - DAC raises reload request each sample; sets sample rate.
// - Eight-bit sample; single-pin mode uses seven bits.
// - Single-pin: zero is half duty on pin 1; pin 0 inverted.
// - Push-pull: zero both low; sign picks which pin pulses high.
`timescale 1ns/100ps
`default_nettype none
module sound_generator_pwm_dac (
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Clock source pin
	input  wire logic        slow_crystal_clock,
	// Sound pins and reload request
	output logic             sound_pin0,
	output logic             sound_pin1,
	output logic             dac_reload_req
);
	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	sound_pkg::sound_regs_t regs_q;
	logic [7:0] status_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic pready_q;
	wire        access  = psel && penable;
	wire [7:0]  index   = paddr[9:2];
	wire        aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	wire        hit_t0l = aligned && index == sound_pkg::IDX_TONE0_LOW;
	wire        hit_t0h = aligned && index == sound_pkg::IDX_TONE0_HIGH;
	wire        hit_t1l = aligned && index == sound_pkg::IDX_TONE1_LOW;
	wire        hit_t1h = aligned && index == sound_pkg::IDX_TONE1_HIGH;
	wire        hit_dac = aligned && index == sound_pkg::IDX_DAC_SAMPLE;
	wire        hit_ctl = aligned && index == sound_pkg::IDX_CONTROL;
	wire        hit_vol = aligned && index == sound_pkg::IDX_VOLUME;
	wire        hit_sta = aligned && index == sound_pkg::IDX_STATUS;
	wire        hit_wo  = hit_t0l | hit_t0h | hit_t1l | hit_t1h | hit_dac
			| hit_ctl | hit_vol;
	// Write-only registers read back as zero; status is read-only
	wire        bad     = access && !(pwrite ? hit_wo : (hit_wo | hit_sta));
	wire        wr_en   = access && pready_q && pwrite && pstrb[0];
	wire [7:0]  wb      = pwdata[7:0];
	wire [31:0] rd_val  = hit_sta ? {24'h000000, status_q} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs_q    <= '0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
			pready_q  <= 1'b0;
		end else begin
			pready_q  <= access && !pready_q;
			if (wr_en && hit_t0l) regs_q.chan0_period[7:0]  <= wb;
			if (wr_en && hit_t0h) regs_q.chan0_period[11:8] <= wb[3:0];
			if (wr_en && hit_t1l) regs_q.chan1_period[7:0]  <= wb;
			if (wr_en && hit_t1h) regs_q.chan1_period[11:8] <= wb[3:0];
			if (wr_en && hit_dac) regs_q.dac_sample <= wb;
			if (wr_en && hit_ctl) regs_q.control    <= {1'b0, wb[6:0]};
			if (wr_en && hit_vol) regs_q.volume     <= wb;
			prdata_q  <= (access && !pwrite && !pready_q) ? rd_val
					: 32'h00000000;
			pslverr_q <= bad && !pready_q;
		end
	end
	// One wait state, so every bus output comes from a flop
	assign pready  = pready_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------------------------------
	// Sound clock
	// ----------------------------------------------------------------
	logic xtal_s1_q, xtal_s2_q, xtal_s3_q;
	logic [3:0] pre_q;
	logic tick_q;
	wire [2:0] clk_sel = regs_q.control[sound_pkg::CTL_CLK_LSB +: 3];
	logic tick_d;
	always_comb begin
		case (clk_sel)
		3'h0:       tick_d = pre_q[0] == 1'b1;
		3'h1, 3'h5: tick_d = pre_q[1:0] == 2'h3;
		3'h2, 3'h6: tick_d = pre_q[2:0] == 3'h7;
		3'h3:       tick_d = pre_q == 4'hF;
		3'h4:       tick_d = 1'b1;
		default:    tick_d = xtal_s2_q && !xtal_s3_q;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_s1_q <= 1'b0;
			xtal_s2_q <= 1'b0;
			xtal_s3_q <= 1'b0;
			pre_q     <= 4'h0;
			tick_q    <= 1'b0;
		end else begin
			xtal_s1_q <= slow_crystal_clock;
			xtal_s2_q <= xtal_s1_q;
			xtal_s3_q <= xtal_s2_q;
			pre_q     <= pre_q + 4'h1;
			tick_q    <= tick_d;
		end
	end

	// ----------------------------------------------------------------
	// Tone, noise and sample-rate dividers
	// ----------------------------------------------------------------
	wire dac_mode = regs_q.control[sound_pkg::CTL_DAC_FUNC];
	logic [11:0] div0_q, div1_q;
	logic [5:0]  ndiv_q;
	logic        sq0_q, sq1_q;
	logic [16:0] lfsr_q;
	// Divider reloads at period so it runs 1000H minus period ticks
	wire wrap0 = tick_q && div0_q == 12'hFFF;
	wire wrap1 = tick_q && div1_q == 12'hFFF;
	wire nwrap = tick_q && ndiv_q == 6'h3F;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div0_q <= 12'h000;
			div1_q <= 12'h000;
			ndiv_q <= 6'h00;
			sq0_q  <= 1'b0;
			sq1_q  <= 1'b0;
			lfsr_q <= sound_pkg::LFSR_SEED;
		end else begin
			if (wrap0) begin
				div0_q <= regs_q.chan0_period;
				sq0_q  <= !sq0_q;
			end else if (tick_q) begin
				div0_q <= div0_q + 12'h001;
			end
			if (wrap1) begin
				div1_q <= regs_q.chan1_period;
				sq1_q  <= !sq1_q;
			end else if (tick_q) begin
				div1_q <= div1_q + 12'h001;
			end
			if (nwrap) begin
				ndiv_q <= regs_q.chan1_period[5:0];
				lfsr_q <= {lfsr_q[15:0], lfsr_q[16] ^ lfsr_q[13]};
			end else if (tick_q) begin
				ndiv_q <= ndiv_q + 6'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// DAC segment counter; a repeat counter loaded from channel 1 high bits counts PWM repeats
	// ----------------------------------------------------------------
	logic [6:0] seg_q;
	logic [7:0] sample_q;
	logic       reload_q;
	// Noise divider sets segment rate; channel 1 high divider sets
	// repeats per sample
	wire seg_end = nwrap && seg_q == sound_pkg::SEGMENTS;
	logic [5:0] rep_q;
	wire sample_end = seg_end && rep_q == 6'h3F;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_q    <= 7'h00;
			rep_q    <= 6'h00;
			sample_q <= sound_pkg::RST_BYTE;
			reload_q <= 1'b0;
		end else begin
			if (nwrap) seg_q <= seg_q + 7'h01;
			if (sample_end) rep_q <= regs_q.chan1_period[11:6];
			else if (seg_end) rep_q <= rep_q + 6'h01;
			// Latch the sample at period start so pulses stay whole
			if (sample_end) sample_q <= regs_q.dac_sample;
			reload_q <= dac_mode && sample_end;
		end
	end

	// ----------------------------------------------------------------
	// Volume and output mixing
	// ----------------------------------------------------------------
	logic [3:0] vol_ph_q;
	wire en0 = regs_q.control[sound_pkg::CTL_BIT1];
	wire en1 = regs_q.control[sound_pkg::CTL_BIT2];
	wire nsel = regs_q.control[sound_pkg::CTL_BIT3];
	wire src1 = nsel ? lfsr_q[0] : sq1_q;
	wire [3:0] chan0_volume = regs_q.volume[3:0];
	wire [3:0] chan1_volume = regs_q.volume[7:4];
	// Volume gates the waveform with an n/16 duty pulse
	wire gate0 = vol_ph_q < chan0_volume;
	wire gate1 = vol_ph_q < chan1_volume;
	wire tone0 = en0 && sq0_q && gate0;
	wire tone1 = en1 && src1 && gate1;
	// One channel alone drives both pins: twice the swing, 32 levels
	wire only0 = en0 && !en1;
	wire only1 = en1 && !en0;
	wire t_pin0 = only1 ? tone1 : tone0;
	wire t_pin1 = only0 ? tone0 : tone1;

	wire [1:0] out_mode    = regs_q.control[3:2];
	wire       out_inhibit = regs_q.control[sound_pkg::CTL_BIT1];
	wire       neg   = sample_q[7];
	wire [6:0] mag   = neg ? 7'(-sample_q) : sample_q[6:0];
	wire       pulse = seg_q < mag;
	// Seven-bit signed sample as offset binary: 0 gives 64 of 128
	wire [6:0] sp    = {~sample_q[6], sample_q[5:0]};
	wire       sp_hi = seg_q < sp;
	logic d_pin0, d_pin1;
	always_comb begin
		case (out_mode)
		sound_pkg::MODE_SINGLE: begin
			d_pin1 = sp_hi;
			d_pin0 = !sp_hi;
		end
		sound_pkg::MODE_TWO: begin
			d_pin1 = !neg && pulse;
			d_pin0 = !(neg && pulse);
		end
		sound_pkg::MODE_PUSH: begin
			d_pin1 = !neg && pulse;
			d_pin0 = neg && pulse;
		end
		default: begin
			d_pin1 = 1'b0;
			d_pin0 = 1'b0;
		end
		endcase
	end

	logic pin0_q, pin1_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vol_ph_q <= 4'h0;
			pin0_q   <= 1'b0;
			pin1_q   <= 1'b0;
			status_q <= sound_pkg::RST_BYTE;
		end else begin
			if (tick_q) vol_ph_q <= vol_ph_q + 4'h1;
			if (dac_mode) begin
				pin0_q <= !out_inhibit && d_pin0;
				pin1_q <= !out_inhibit && d_pin1;
			end else begin
				pin0_q <= t_pin0;
				pin1_q <= t_pin1;
			end
			status_q <= {4'h0, lfsr_q[0], sq1_q, sq0_q, dac_mode};
		end
	end
	assign sound_pin0     = pin0_q;
	assign sound_pin1     = pin1_q;
	assign dac_reload_req = reload_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_inhibit_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(dac_mode && out_inhibit)
		|-> !sound_pin0 && !sound_pin1)
		else $error("inhibited DAC drove a pin");

	a_push_exclusive: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(dac_mode && out_mode == sound_pkg::MODE_PUSH)
		|-> !(sound_pin0 && sound_pin1))
		else $error("push-pull drove both pins");

	a_reload_pulse: assert property (
		@(posedge pclk) disable iff (!presetn)
		dac_reload_req
		|=> !dac_reload_req)
		else $error("reload request longer than a cycle");

	a_reload_mode: assert property (
		@(posedge pclk) disable iff (!presetn)
		dac_reload_req
		|-> $past(dac_mode))
		else $error("reload outside DAC mode");

	a_tone_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(!dac_mode && !en0 && !en1)
		|-> !sound_pin0 && !sound_pin1)
		else $error("disabled channels produced sound");

	a_silent_vol: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(!dac_mode && chan0_volume == 4'h0 && chan1_volume == 4'h0)
		|-> !sound_pin0 && !sound_pin1)
		else $error("zero volume produced sound");

	a_single_inv: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(dac_mode && !out_inhibit && out_mode == sound_pkg::MODE_SINGLE)
		|-> sound_pin0 != sound_pin1)
		else $error("single-pin outputs not inverse");

	a_two_ended: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(dac_mode && !out_inhibit && out_mode == sound_pkg::MODE_TWO)
		|-> sound_pin0 || !sound_pin1)
		else $error("two-ended pins both wrong");

	a_tone_period: assert property (
		@(posedge pclk) disable iff (!presetn)
		wrap0
		|=> div0_q == $past(regs_q.chan0_period))
		else $error("tone divider did not reload");

	a_tone1_period: assert property (
		@(posedge pclk) disable iff (!presetn)
		wrap1
		|=> div1_q == $past(regs_q.chan1_period))
		else $error("channel 1 divider did not reload");

	a_tone_toggle: assert property (
		@(posedge pclk) disable iff (!presetn)
		wrap0
		|=> sq0_q != $past(sq0_q))
		else $error("tone square did not toggle");

	a_noise_reload: assert property (
		@(posedge pclk) disable iff (!presetn)
		nwrap
		|=> ndiv_q == $past(regs_q.chan1_period[5:0]))
		else $error("noise divider did not reload");

	a_sample_latch: assert property (
		@(posedge pclk) disable iff (!presetn)
		sample_end
		|=> sample_q == $past(regs_q.dac_sample))
		else $error("sample not taken at period end");

	a_repeat_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		sample_end
		|=> rep_q == $past(regs_q.chan1_period[11:6]))
		else $error("repeat count not reloaded");

	a_reserved_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(dac_mode && out_mode == 2'h2)
		|-> !sound_pin0 && !sound_pin1)
		else $error("reserved output mode drove a pin");

	a_push_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(dac_mode && out_mode == sound_pkg::MODE_PUSH && sample_q == 8'h00)
		|-> !sound_pin0 && !sound_pin1)
		else $error("push-pull zero sample drove a pin");

	a_two_positive: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(dac_mode && !out_inhibit && out_mode == sound_pkg::MODE_TWO && !neg)
		|-> sound_pin0)
		else $error("two-ended positive sample dropped pin 0");

	a_single_chan: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(!dac_mode && en0 && !en1)
		|-> sound_pin0 == sound_pin1)
		else $error("lone channel did not drive both pins");
endmodule : sound_generator_pwm_dac
`default_nettype wire

// ---- tb/sound_load_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module sound_load_model (
	// Clock and clear
	input  wire logic        clk,
	input  wire logic        clr_n,
	// Pins and reload
	input  wire logic        pin0,
	input  wire logic        pin1,
	input  wire logic        reload,
	// High-time tallies and sample period length
	output logic      [15:0] run0,
	output logic      [15:0] run1,
	output logic      [15:0] lat0,
	output logic      [15:0] lat1,
	output logic      [15:0] per_len
);
	logic [15:0] acc0;
	logic [15:0] acc1;
	logic [15:0] len;
	// ----------------------------------------------------------------
	// Passive load: running tally, and one tally per sample period
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge clr_n) begin
		if (!clr_n) begin
			{run0, run1, acc0, acc1, len} <= '0;
			{lat0, lat1, per_len} <= '0;
		end else begin
			run0 <= run0 + 16'(pin0);
			run1 <= run1 + 16'(pin1);
			acc0 <= reload ? 16'h0000 : acc0 + 16'(pin0);
			acc1 <= reload ? 16'h0000 : acc1 + 16'(pin1);
			len  <= reload ? 16'h0000 : len + 16'h0001;
			if (reload) begin
				lat0    <= acc0 + 16'(pin0);
				lat1    <= acc1 + 16'(pin1);
				per_len <= len + 16'h0001;
			end
		end
	end
endmodule : sound_load_model
`default_nettype wire

// ---- tb/test_sound_generator_pwm_dac.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_sound_generator_pwm_dac;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic        xtal = 1'b0;
	logic        clr_n = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, pin0, pin1, reload;
	logic [15:0] run0, run1, lat0, lat1, per_len;
	integer      fails = 0, n_tests = 0, seed = 32'h531a, i, s, cyc = 0;
	always #5 pclk = ~pclk;
	always #15000 xtal = ~xtal;
	always @(posedge pclk) cyc <= cyc + 1;
	sound_generator_pwm_dac uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slow_crystal_clock(xtal), .sound_pin0(pin0), .sound_pin1(pin1),
		.dac_reload_req(reload));
	sound_load_model load (.clk(pclk), .clr_n(clr_n), .pin0(pin0),
		.pin1(pin1), .reload(reload), .run0(run0), .run1(run1), .lat0(lat0),
		.lat1(lat1), .per_len(per_len));
	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic near(input string nm, input logic [31:0] e,
		input logic [31:0] g, input logic [31:0] t);
		n_tests++;
		if ((g + t >= e && g <= e + t) !== 1'b1) begin
			fails++;
			$display("unexpected %s: expected %0d seen %0d", nm, e, g);
		end
	endtask : near
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [7:0] d);
		integer w;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		w = 0;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'b1 && w < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w >= 50)
			chk("bus answer", 1, 0);
		if (w >= 50)
			final_report();
	endtask : apb
	// Bounded wait for a status bit to flip
	task automatic wchg(input int b);
		logic v;
		int c;
		v = rd[b];
		c = 0;
		do begin
			apb(1'b0, sound_pkg::IDX_STATUS, 8'h00);
			c++;
		end while (rd[b] === v && c < 4000);
		if (c >= 4000)
			chk("status toggle", 1, 0);
		if (c >= 4000)
			final_report();
	endtask : wchg
	task automatic gap(input int b, input int e);
		apb(1'b0, sound_pkg::IDX_STATUS, 8'h00);
		wchg(b);
		s = cyc;
		wchg(b);
		near("tone half period", e, cyc - s, 3);
	endtask : gap
	task automatic quiet(input int n, input int e, input int t);
		clr_n <= 1'b0;
		@(posedge pclk);
		clr_n <= 1'b1;
		repeat (n) @(posedge pclk);
		near("pin high time", e, run0 + run1, t);
	endtask : quiet
	task automatic wrel();
		int w;
		w = 0;
		do begin
			@(posedge pclk);
			w++;
		end while (reload !== 1'b1 && w < 4000);
		if (w >= 4000)
			chk("reload pulse", 1, 0);
		if (w >= 4000)
			final_report();
	endtask : wrel
	// Expected high cycles per 512-cycle sample: {pin0, pin1}
	function automatic logic [31:0] exp_hi(input logic [1:0] m,
		input logic h, input int v);
		int a;
		a = (v < 0 ? -v : v) * 4;
		if (h || m == 2'b10)
			return 32'h0;
		if (m == 2'b11)
			return v < 0 ? {16'(a), 16'h0} : {16'h0, 16'(a)};
		if (m == 2'b01)
			return v < 0 ? {16'(512 - a), 16'h0} : {16'd512, 16'(a)};
		return {16'(256 - v * 4), 16'(256 + v * 4)};
	endfunction : exp_hi
	task automatic dac(input logic [1:0] m, input logic h, input int v);
		apb(1'b1, sound_pkg::IDX_DAC_SAMPLE, 8'(v));
		apb(1'b1, sound_pkg::IDX_CONTROL, {4'h4, m, h, 1'b1});
		repeat (3) wrel();
		@(posedge pclk);
		chk("sample period", 512, per_len);
		chk("pin high per sample", exp_hi(m, h, v), {lat0, lat1});
	endtask : dac
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		clr_n <= 1'b1;
		@(posedge pclk);
		chk("pins after reset", 3'b000, {pin0, pin1, reload});
		apb(1'b0, sound_pkg::IDX_CONTROL, 8'h00);
		chk("write-only read", 33'h0, {err, rd});
		apb(1'b0, 8'h15, 8'h00);
		chk("unmapped read error", 1, err);
		apb(1'b1, sound_pkg::IDX_STATUS, 8'hFF);
		chk("status write error", 1, err);
		// Half period 1000H-F38 = 200 sound clocks on both channels
		for (i = 0; i < 4; i++)
			apb(1'b1, 8'(sound_pkg::IDX_TONE0_LOW + i), i[0] ? 8'h0F : 8'h38);
		apb(1'b1, sound_pkg::IDX_VOLUME, 8'hFF);
		for (i = 0; i < 5; i++) begin
			apb(1'b1, sound_pkg::IDX_CONTROL, {1'b0, i[2:0], 4'b0010});
			gap(1, i == 4 ? 200 : 400 << i);
		end
		apb(1'b1, sound_pkg::IDX_CONTROL, 8'h44);
		gap(2, 200);
		apb(1'b1, sound_pkg::IDX_CONTROL, 8'h40);
		quiet(800, 0, 0);
		apb(1'b1, sound_pkg::IDX_CONTROL, 8'h42);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, sound_pkg::IDX_VOLUME, {4'h0, 4'(i * 5)});
			quiet(3200, i * 1000, i == 0 ? 0 : 200);
		end
		// Noise clock is the sound clock when the low six bits are 3F
		apb(1'b1, sound_pkg::IDX_TONE1_LOW, 8'h3F);
		apb(1'b1, sound_pkg::IDX_VOLUME, 8'hF0);
		apb(1'b1, sound_pkg::IDX_CONTROL, 8'h48);
		quiet(800, 0, 0);
		apb(1'b1, sound_pkg::IDX_CONTROL, 8'h4C);
		quiet(1000, 1000, 999);
		chk("noise pins change", 1, run0 + run1 != 1000);
		dac(2'b00, 1'b0, 0);
		apb(1'b0, sound_pkg::IDX_STATUS, 8'h00);
		chk("dac function", 1, rd[0]);
		dac(2'b00, 1'b0, 63);
		dac(2'b00, 1'b0, -64);
		dac(2'b00, 1'b0, -20);
		dac(2'b01, 1'b0, 127);
		dac(2'b01, 1'b0, -127);
		dac(2'b01, 1'b1, 50);
		dac(2'b10, 1'b0, 40);
		dac(2'b11, 1'b0, 0);
		dac(2'b11, 1'b0, 1);
		dac(2'b11, 1'b0, -1);
		for (i = 0; i < 6; i++)
			dac(i[0] ? 2'b01 : 2'b11, 1'b0, $random(seed) % 128);
		dac(2'b00, 1'b0, 0);
		apb(1'b1, sound_pkg::IDX_DAC_SAMPLE, 8'($random(seed)));
		repeat (3) wrel();
		@(posedge pclk);
		chk("single pin sum", 512, lat0 + lat1);
		final_report();
	end
endmodule : test_sound_generator_pwm_dac
`default_nettype wire
